// ### inc/mlc_logger_regs.vh
// Register map, field positions, reset values and timing counts of the logging controller.
`ifndef MLC_LOGGER_REGS_VH
`define MLC_LOGGER_REGS_VH

// Register byte addresses.
`define MLC_ADDR_CTRL 10'h000
`define MLC_ADDR_STATUS 10'h004
`define MLC_ADDR_CMD 10'h008
`define MLC_ADDR_IRQ_STAT 10'h00c
`define MLC_ADDR_IRQ_MASK 10'h010
`define MLC_ADDR_TIME_LEFT 10'h014
`define MLC_ADDR_WR_PTR 10'h018
`define MLC_ADDR_USED 10'h01c
`define MLC_ADDR_CHCFG 10'h020
`define MLC_ADDR_RANGE 10'h040
`define MLC_ADDR_LABEL 10'h100

// CTRL fields.
`define MLC_CTRL_WRAP 0
`define MLC_CTRL_TRIG_LSB 1
`define MLC_CTRL_PER_LSB 3
`define MLC_CTRL_BL_TEMP 7
`define MLC_CTRL_RESET 8'h00

// Triggering modes.
`define MLC_TRIG_ALWAYS 2'h0
`define MLC_TRIG_HIGH 2'h1
`define MLC_TRIG_LOW 2'h2

// CMD bits.
`define MLC_CMD_CONFIRM 0
`define MLC_CMD_FREED 1

// Interrupt status bits.
`define MLC_IRQ_RECORD 0
`define MLC_IRQ_WARN 1
`define MLC_IRQ_FREED 2

// Remaining-time status codes.
`define MLC_TL_NORMAL 2'h0
`define MLC_TL_DISABLED 2'h1
`define MLC_TL_STOPPED 2'h2
`define MLC_TL_OVERWRITE 2'h3

// Channel record types and sensor types.
`define MLC_REC_NONE 2'h0
`define MLC_REC_CURRENT 2'h1
`define MLC_REC_AVERAGE 2'h2
`define MLC_SENS_INACTIVE 2'h0

// Channel configuration fields.
`define MLC_CH_SENS_LSB 2
`define MLC_CH_FILT_LSB 4
`define MLC_CH_OFS_LSB 8

// Limits.
`define MLC_NUM_CH 8
`define MLC_LABEL_LEN 9
`define MLC_PER_CHOICES 15
`define MLC_FILT_MAX 3'h5
`define MLC_RANGE_MAX 16'sd9999
`define MLC_RANGE_MIN -16'sd9999
`define MLC_OFS_MAX 8'sd99
`define MLC_OFS_MIN -8'sd99
`define MLC_MEM_WORDS 13'h1000

// Backlight timing in seconds.
`define MLC_BL_KEY_SEC 7'h3c
`define MLC_BL_PWRUP_SEC 7'h0a

`endif

// ### design/mlc_logger.v
// Recording controller of an eight-channel temperature logger with register port.
`timescale 1ns/1ps
`include "mlc_logger_regs.vh"

module mlc_logger
(
  // Clock and reset.
  input wire clk_i,
  input wire arst_n_i,
  // Register port.
  input wire [9:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  output reg irq_o,
  // Real-time clock.
  input wire rtc_tick_i,
  input wire [11:0] rtc_sec_of_hour_i,
  // Measurements and digital gating input.
  input wire meas_valid_i,
  input wire [2:0] meas_ch_i,
  input wire [15:0] meas_val_i,
  input wire gate_in_i,
  // Non-volatile state seen at power-up.
  input wire nv_full_i,
  input wire nv_overwrite_i,
  // Measurement memory.
  output reg mem_wr_o,
  output reg [11:0] mem_addr_o,
  output reg [18:0] mem_data_o,
  // Keys and backlight.
  input wire key_i,
  output reg key_act_o,
  output reg backlight_o
);

  localparam [1:0] S_IDLE = 2'b01;
  localparam [1:0] S_SCAN = 2'b10;

  // Interval length in seconds; every choice divides one hour.
  function [11:0] per_sec;
    input [3:0] idx;
    begin
      case (idx)
        4'h0: per_sec = 12'd1;
        4'h1: per_sec = 12'd2;
        4'h2: per_sec = 12'd5;
        4'h3: per_sec = 12'd10;
        4'h4: per_sec = 12'd15;
        4'h5: per_sec = 12'd20;
        4'h6: per_sec = 12'd30;
        4'h7: per_sec = 12'd60;
        4'h8: per_sec = 12'd120;
        4'h9: per_sec = 12'd300;
        4'ha: per_sec = 12'd600;
        4'hb: per_sec = 12'd900;
        4'hc: per_sec = 12'd1200;
        4'hd: per_sec = 12'd1800;
        default: per_sec = 12'd3600;
      endcase
    end
  endfunction

  function signed [15:0] clamp_range;
    input signed [15:0] v;
    begin
      if (v > `MLC_RANGE_MAX)
        clamp_range = `MLC_RANGE_MAX;
      else if (v < `MLC_RANGE_MIN)
        clamp_range = `MLC_RANGE_MIN;
      else
        clamp_range = v;
    end
  endfunction

  reg [7:0] ctrl_q;
  reg [2:0] irq_mask_q;
  reg [15:0] chcfg_q [0:7];
  reg signed [15:0] lo_q [0:7];
  reg signed [15:0] hi_q [0:7];
  reg [7:0] label_q [0:71];
  reg signed [15:0] filt_q [0:7];
  reg signed [15:0] avg_q [0:7];
  reg [1:0] state_q;
  reg [2:0] scan_q;
  reg [11:0] wr_ptr_q;
  reg [12:0] used_q;
  reg full_q;
  reg ovw_q;
  reg warn_q;
  reg init_q;
  reg [2:0] irq_stat_q;
  reg [6:0] bl_cnt_q;
  reg [4:0] div_cnt_q;
  reg [23:0] div_num_q;
  reg [3:0] div_rem_q;
  reg [23:0] time_left_q;

  wire [1:0] trig = ctrl_q[`MLC_CTRL_TRIG_LSB +: 2];
  wire [3:0] per_idx = ctrl_q[`MLC_CTRL_PER_LSB +: 4];
  wire wrap_mode = ctrl_q[`MLC_CTRL_WRAP];
  wire bl_temp = ctrl_q[`MLC_CTRL_BL_TEMP];
  wire [11:0] period = per_sec(per_idx);
  wire [2:0] rch = reg_addr_i[4:2];
  wire [2:0] lab_ch = reg_addr_i[8:6];
  wire [3:0] lab_pos = reg_addr_i[5:2];
  wire [6:0] lab_idx = {1'b0, lab_ch} * 7'd9 + {3'h0, lab_pos};
  wire is_chcfg = reg_addr_i[9:5] == `MLC_ADDR_CHCFG >> 5;
  wire is_range = reg_addr_i[9:5] == `MLC_ADDR_RANGE >> 5;
  wire is_label = reg_addr_i[9:8] == 2'h1 && lab_pos < 4'd9;
  wire cmd_wr = reg_wr_i && reg_addr_i == `MLC_ADDR_CMD;
  wire confirm = cmd_wr && reg_wdata_i[`MLC_CMD_CONFIRM];
  wire freed = cmd_wr && reg_wdata_i[`MLC_CMD_FREED];

  wire rec_tick = rtc_tick_i && (rtc_sec_of_hour_i % period) == 12'h000;

  reg gate_ok;
  always @*
  begin
    case (trig)
      `MLC_TRIG_ALWAYS: gate_ok = 1'b1;
      `MLC_TRIG_HIGH: gate_ok = gate_in_i;
      `MLC_TRIG_LOW: gate_ok = ~gate_in_i;
      default: gate_ok = 1'b0;
    endcase
  end

  // Count of recording channels.
  reg [3:0] nch;
  integer k;
  always @*
  begin
    nch = 4'h0;
    for (k = 0; k < 8; k = k + 1)
      if (chcfg_q[k][1:0] != `MLC_REC_NONE)
        nch = nch + 4'h1;
  end

  wire [12:0] free_words = `MLC_MEM_WORDS - used_q;
  wire [1:0] scan_mode = chcfg_q[scan_q][1:0];
  wire scan_last = scan_q == 3'h7;
  wire mem_end = used_q == `MLC_MEM_WORDS - 13'h0001;

  // Configuration registers written by software.
  integer i;
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_q <= `MLC_CTRL_RESET;
      irq_mask_q <= 3'h0;
      for (i = 0; i < 8; i = i + 1)
      begin
        chcfg_q[i] <= 16'h0000;
        lo_q[i] <= 16'sh0000;
        hi_q[i] <= 16'sh0000;
      end
      for (i = 0; i < 72; i = i + 1)
        label_q[i] <= 8'h20;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == `MLC_ADDR_CTRL)
      begin
        ctrl_q <= reg_wdata_i[7:0];
        if (reg_wdata_i[`MLC_CTRL_PER_LSB +: 4] >= `MLC_PER_CHOICES)
          ctrl_q[`MLC_CTRL_PER_LSB +: 4] <= 4'he;
      end
      if (reg_addr_i == `MLC_ADDR_IRQ_MASK)
        irq_mask_q <= reg_wdata_i[2:0];
      if (is_chcfg)
      begin
        chcfg_q[rch][3:0] <= reg_wdata_i[3:0];
        if (reg_wdata_i[`MLC_CH_SENS_LSB +: 2] == `MLC_SENS_INACTIVE)
          chcfg_q[rch][1:0] <= `MLC_REC_NONE;
        else if (reg_wdata_i[1:0] == 2'h3)
          chcfg_q[rch][1:0] <= `MLC_REC_NONE;
        if (reg_wdata_i[`MLC_CH_FILT_LSB +: 3] > `MLC_FILT_MAX)
          chcfg_q[rch][6:4] <= `MLC_FILT_MAX;
        else
          chcfg_q[rch][6:4] <= reg_wdata_i[`MLC_CH_FILT_LSB +: 3];
        chcfg_q[rch][7] <= 1'b0;
        if ($signed(reg_wdata_i[15:8]) > `MLC_OFS_MAX)
          chcfg_q[rch][15:8] <= `MLC_OFS_MAX;
        else if ($signed(reg_wdata_i[15:8]) < `MLC_OFS_MIN)
          chcfg_q[rch][15:8] <= `MLC_OFS_MIN;
        else
          chcfg_q[rch][15:8] <= reg_wdata_i[15:8];
      end
      // limits clamped and stored in order.
      if (is_range)
      begin
        if ($signed(reg_wdata_i[15:0]) > $signed(reg_wdata_i[31:16]))
        begin
          lo_q[rch] <= clamp_range(reg_wdata_i[31:16]);
          hi_q[rch] <= clamp_range(reg_wdata_i[15:0]);
        end
        else
        begin
          lo_q[rch] <= clamp_range(reg_wdata_i[15:0]);
          hi_q[rch] <= clamp_range(reg_wdata_i[31:16]);
        end
      end
      if (is_label)
        label_q[lab_idx] <= reg_wdata_i[7:0];
    end
  end

  // Input conditioning per channel.
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_cond
      wire signed [16:0] diff = {meas_val_i[15], meas_val_i} - {filt_q[g][15], filt_q[g]};
      wire signed [16:0] step = diff >>> chcfg_q[g][6:4];
      wire signed [15:0] filt_d = filt_q[g] + step[15:0];
      wire signed [15:0] res = filt_d + {{8{chcfg_q[g][15]}}, chcfg_q[g][15:8]};
      wire signed [16:0] adiff = {res[15], res} - {avg_q[g][15], avg_q[g]};
      wire signed [16:0] astep = adiff >>> 2;
      always @(posedge clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          filt_q[g] <= 16'sh0000;
          avg_q[g] <= 16'sh0000;
        end
        else if (meas_valid_i && meas_ch_i == g)
        begin
          filt_q[g] <= filt_d;
          avg_q[g] <= avg_q[g] + astep[15:0];
        end
      end
    end
  endgenerate

  // Recording sequencer, memory state and warnings.
  wire [2:0] irq_set = {freed, 1'b0, 1'b0};
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_q <= S_IDLE;
      scan_q <= 3'h0;
      wr_ptr_q <= 12'h000;
      used_q <= 13'h0000;
      full_q <= 1'b0;
      ovw_q <= 1'b0;
      warn_q <= 1'b0;
      init_q <= 1'b1;
      irq_stat_q <= 3'h0;
      mem_wr_o <= 1'b0;
      mem_addr_o <= 12'h000;
      mem_data_o <= 19'h00000;
    end
    else
    begin
      mem_wr_o <= 1'b0;
      if (reg_wr_i && reg_addr_i == `MLC_ADDR_IRQ_STAT)
        irq_stat_q <= (irq_stat_q & ~reg_wdata_i[2:0]) | irq_set;
      else
        irq_stat_q <= irq_stat_q | irq_set;
      if (confirm)
        warn_q <= 1'b0;
      // full warning raised again after power-up; wrap_mode is still at reset (0) here.
      if (init_q)
      begin
        init_q <= 1'b0;
        full_q <= nv_full_i & ~wrap_mode;
        ovw_q <= nv_overwrite_i & wrap_mode;
        if ((nv_full_i & ~wrap_mode) | (nv_overwrite_i & wrap_mode))
          warn_q <= 1'b1;
      end
      // full flag cleared when memory is freed.
      if (freed)
      begin
        used_q <= 13'h0000;
        full_q <= 1'b0;
        ovw_q <= 1'b0;
      end
      case (state_q)
        S_IDLE:
        begin
          // halted while full in stop mode.
          if (rec_tick && gate_ok && !full_q && !freed && nch != 4'h0)
          begin
            state_q <= S_SCAN;
            scan_q <= 3'h0;
          end
        end
        S_SCAN:
        begin
          if (scan_mode != `MLC_REC_NONE && !full_q)
          begin
            // average or corrected current value stored per channel record type.
            mem_wr_o <= 1'b1;
            mem_addr_o <= wr_ptr_q;
            mem_data_o <= {scan_q, scan_mode == `MLC_REC_AVERAGE ? avg_q[scan_q]
                                                                 : g_res(scan_q)};
            // pointer wraps to the start address.
            wr_ptr_q <= wr_ptr_q + 12'h001;
            if (mem_end || used_q == `MLC_MEM_WORDS)
            begin
              if (wrap_mode)
              begin
                // warn on the first overwrite only.
                if (!ovw_q && used_q == `MLC_MEM_WORDS)
                begin
                  warn_q <= 1'b1;
                  irq_stat_q[`MLC_IRQ_WARN] <= 1'b1;
                end
                ovw_q <= used_q == `MLC_MEM_WORDS;
                used_q <= `MLC_MEM_WORDS;
              end
              else
              begin
                // full at the end of memory.
                full_q <= 1'b1;
                warn_q <= 1'b1;
                irq_stat_q[`MLC_IRQ_WARN] <= 1'b1;
                used_q <= `MLC_MEM_WORDS;
              end
            end
            else
              used_q <= used_q + 13'h0001;
          end
          if (scan_last || full_q)
          begin
            state_q <= S_IDLE;
            irq_stat_q[`MLC_IRQ_RECORD] <= 1'b1;
          end
          scan_q <= scan_q + 3'h1;
        end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  // Corrected current value of a channel.
  function signed [15:0] g_res;
    input [2:0] ch;
    begin
      g_res = filt_q[ch] + {{8{chcfg_q[ch][15]}}, chcfg_q[ch][15:8]};
    end
  endfunction

  // free words times interval over channel count.
  wire [23:0] div_num0 = free_words[11:0] * period + (free_words[12] ? {period, 12'h000} : 24'h0);
  wire [4:0] div_t = {div_rem_q, div_num_q[23]};
  wire div_ge = div_t >= {1'b0, nch};
  wire [4:0] div_sub = div_t - {1'b0, nch};
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      div_cnt_q <= 5'h00;
      div_num_q <= 24'h000000;
      div_rem_q <= 4'h0;
      time_left_q <= 24'h000000;
    end
    else if (div_cnt_q == 5'h00 || nch == 4'h0)
    begin
      div_cnt_q <= 5'd24;
      div_num_q <= div_num0;
      div_rem_q <= 4'h0;
    end
    else
    begin
      div_rem_q <= div_ge ? div_sub[3:0] : div_t[3:0];
      div_num_q <= {div_num_q[22:0], div_ge};
      div_cnt_q <= div_cnt_q - 5'h01;
      if (div_cnt_q == 5'h01)
        time_left_q <= {div_num_q[22:0], div_ge};
    end
  end

  reg [1:0] tl_code;
  always @*
  begin
    if (nch == 4'h0)
      tl_code = `MLC_TL_DISABLED;
    else if (full_q)
      tl_code = `MLC_TL_STOPPED;
    else if (ovw_q)
      tl_code = `MLC_TL_OVERWRITE;
    else
      tl_code = `MLC_TL_NORMAL;
  end

  // Backlight and key filtering.
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      bl_cnt_q <= `MLC_BL_PWRUP_SEC;
      backlight_o <= 1'b1;
      key_act_o <= 1'b0;
    end
    else
    begin
      // first key only wakes the backlight.
      key_act_o <= key_i && (!bl_temp || backlight_o);
      if (key_i)
        bl_cnt_q <= `MLC_BL_KEY_SEC;
      else if (rtc_tick_i && bl_cnt_q != 7'h00)
        bl_cnt_q <= bl_cnt_q - 7'h01;
      backlight_o <= !bl_temp || key_i || (bl_cnt_q != 7'h00 &&
                     !(rtc_tick_i && bl_cnt_q == 7'h01));
    end
  end

  // Read data and interrupt line.
  reg [31:0] rdata_d;
  always @*
  begin
    rdata_d = 32'h00000000;
    if (reg_addr_i == `MLC_ADDR_CTRL)
      rdata_d = {24'h000000, ctrl_q};
    else if (reg_addr_i == `MLC_ADDR_STATUS)
      rdata_d = {26'h0000000, backlight_o, tl_code, warn_q, ovw_q, full_q};
    else if (reg_addr_i == `MLC_ADDR_IRQ_STAT)
      rdata_d = {29'h00000000, irq_stat_q};
    else if (reg_addr_i == `MLC_ADDR_IRQ_MASK)
      rdata_d = {29'h00000000, irq_mask_q};
    else if (reg_addr_i == `MLC_ADDR_TIME_LEFT)
      rdata_d = {8'h00, time_left_q};
    else if (reg_addr_i == `MLC_ADDR_WR_PTR)
      rdata_d = {20'h00000, wr_ptr_q};
    else if (reg_addr_i == `MLC_ADDR_USED)
      rdata_d = {19'h00000, used_q};
    else if (is_chcfg)
      rdata_d = {16'h0000, chcfg_q[rch]};
    else if (is_range)
      rdata_d = {hi_q[rch], lo_q[rch]};
    else if (is_label)
      rdata_d = {24'h000000, label_q[lab_idx]};
  end

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      reg_rdata_o <= 32'h00000000;
      irq_o <= 1'b0;
    end
    else
    begin
      reg_rdata_o <= reg_rd_i ? rdata_d : 32'h00000000;
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule // mlc_logger

// ### tb/mlc_mem_model.sv
// Behavioural measurement memory that records the words the controller writes.
`timescale 1ns/1ps
module mlc_mem_model
(
  // Clock.
  input wire clk_i,
  // Write port.
  input wire mem_wr_i,
  input wire [11:0] mem_addr_i,
  input wire [18:0] mem_data_i
);
  int writes = 0;
  logic wrapped = 1'b0;
  logic [11:0] last_addr = 12'h000;
  logic [15:0] last_val [8];
  always @(posedge clk_i)
  begin
    if (mem_wr_i)
    begin
      // A write to the bottom right after the top shows the pointer wrapped.
      if (writes > 0 && last_addr == 12'hfff && mem_addr_i == 12'h000)
        wrapped <= 1'b1;
      writes <= writes + 1;
      last_addr <= mem_addr_i;
      last_val[mem_data_i[18:16]] <= mem_data_i[15:0];
    end
  end
endmodule // mlc_mem_model

// ### tb/mlc_logger_asserts.sv
// Port assertions of the logging controller and their bind.
`timescale 1ns/1ps
`include "mlc_logger_regs.vh"
module mlc_logger_asserts
(
  // Clock and reset.
  input wire clk_i,
  input wire arst_n_i,
  // Register port.
  input wire [9:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [31:0] reg_rdata_o,
  // Recording.
  input wire rtc_tick_i,
  input wire [11:0] rtc_sec_of_hour_i,
  input wire gate_in_i,
  input wire mem_wr_o,
  input wire [11:0] mem_addr_o,
  input wire [18:0] mem_data_o,
  // Keys and backlight.
  input wire key_i,
  input wire key_act_o,
  input wire backlight_o
);
  localparam logic [11:0] PER_SEC [15] = '{12'h001, 12'h002, 12'h005, 12'h00a, 12'h00f,
    12'h014, 12'h01e, 12'h03c, 12'h078, 12'h12c, 12'h258, 12'h384, 12'h4b0, 12'h708, 12'he10};
  reg [3:0] age_q;
  reg [3:0] per_q;
  reg [1:0] trig_q;
  reg [11:0] sec_q;
  reg gate_q;
  wire gate_ok = trig_q == 2'h0 || (trig_q == 2'h1 && gate_q) || (trig_q == 2'h2 && !gate_q);
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      age_q <= 4'hf;
      per_q <= 4'h0;
      trig_q <= 2'h0;
      sec_q <= 12'h000;
      gate_q <= 1'b0;
    end
    else
    begin
      // Mirrors interval and gating mode as software sets them.
      if (reg_wr_i && reg_addr_i == `MLC_ADDR_CTRL)
      begin
        per_q <= (reg_wdata_i[6:3] > 4'he) ? 4'he : reg_wdata_i[6:3];
        trig_q <= reg_wdata_i[2:1];
      end
      if (rtc_tick_i)
      begin
        sec_q <= rtc_sec_of_hour_i;
        gate_q <= gate_in_i;
        age_q <= 4'h0;
      end
      else if (age_q != 4'hf)
        age_q <= age_q + 4'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_burst;
    mem_wr_o ##1 mem_wr_o;
  endsequence
  chk_wr_window: assert property (mem_wr_o |-> age_q inside {[4'h1:4'h8]})
    else $error("write outside scan");
  chk_wr_aligned: assert property (mem_wr_o |-> sec_q % PER_SEC[per_q] == 12'h000)
    else $error("write off interval");
  chk_wr_gated: assert property (mem_wr_o |-> gate_ok)
    else $error("write while gated");
  chk_addr_step: assert property (s_burst |-> mem_addr_o == $past(mem_addr_o) + 12'h001)
    else $error("address skipped");
  chk_chan_order: assert property (s_burst |-> mem_data_o[18:16] == $past(mem_data_o[18:16]) + 3'h1)
    else $error("channel order");
  chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data without read");
  chk_key_wakes: assert property (key_i |=> backlight_o)
    else $error("key left backlight off");
  chk_key_swallow: assert property (key_i && !backlight_o |=> !key_act_o)
    else $error("wake key acted");
  chk_key_pass: assert property (key_i && backlight_o |=> key_act_o)
    else $error("key dropped");
  chk_act_cause: assert property (key_act_o |-> $past(key_i))
    else $error("action without key");
endmodule // mlc_logger_asserts

bind mlc_logger mlc_logger_asserts chk_u (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .rtc_tick_i(rtc_tick_i),
  .rtc_sec_of_hour_i(rtc_sec_of_hour_i), .gate_in_i(gate_in_i), .mem_wr_o(mem_wr_o),
  .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o), .key_i(key_i), .key_act_o(key_act_o),
  .backlight_o(backlight_o));

// ### tb/mlc_logger_test.sv
// Self-checking bench of the logging controller.
`timescale 1ns/1ps
`include "mlc_logger_regs.vh"
module mlc_logger_test;
  localparam logic [11:0] PER_SEC [15] = '{12'h001, 12'h002, 12'h005, 12'h00a, 12'h00f,
    12'h014, 12'h01e, 12'h03c, 12'h078, 12'h12c, 12'h258, 12'h384, 12'h4b0, 12'h708, 12'he10};
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic tick = 1'b0;
  logic [11:0] sec = 12'h000;
  logic mval = 1'b0;
  logic [15:0] mv = 16'h0;
  logic [2:0] mch = 3'h0;
  logic gate = 1'b0;
  logic nvf = 1'b0;
  logic key = 1'b0;
  wire [31:0] rdata;
  wire irq, mwr, kact, bl;
  wire [11:0] maddr;
  wire [18:0] mdata;
  int mismatches = 0;
  int samples_checked = 0;
  int i, j, n;
  logic [31:0] v;
  logic signed [15:0] a, b;
  always #12.5 clk_i = ~clk_i;
  mlc_logger dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq), .rtc_tick_i(tick),
    .rtc_sec_of_hour_i(sec), .meas_valid_i(mval), .meas_ch_i(mch), .meas_val_i(mv),
    .gate_in_i(gate), .nv_full_i(nvf), .nv_overwrite_i(1'b0), .mem_wr_o(mwr),
    .mem_addr_o(maddr), .mem_data_o(mdata), .key_i(key), .key_act_o(kact), .backlight_o(bl));
  mlc_mem_model mem_u (.clk_i(clk_i), .mem_wr_i(mwr), .mem_addr_i(maddr), .mem_data_i(mdata));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
  begin
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task automatic wr_reg(input logic [9:0] ad, input logic [31:0] d);
  begin
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
    @(posedge clk_i);
  end
  endtask
  task automatic rd_reg(input logic [9:0] ad, output logic [31:0] d);
  begin
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    d = rdata;
    @(posedge clk_i);
  end
  endtask
  // Gives one tick and counts the words written by the scan.
  task automatic tk(input logic [11:0] s, input int exp);
  begin
    n = mem_u.writes;
    sec <= s;
    tick <= 1'b1;
    @(posedge clk_i);
    tick <= 1'b0;
    repeat (12) @(posedge clk_i);
    chk(32'(mem_u.writes - n), 32'(exp));
  end
  endtask
  task automatic kp(output logic ka);
  begin
    key <= 1'b1;
    @(posedge clk_i);
    key <= 1'b0;
    #1;
    ka = kact;
    @(posedge clk_i);
  end
  endtask
  function automatic logic [31:0] rng(input logic signed [15:0] x, input logic signed [15:0] y);
    x = x > 16'sd9999 ? 16'sd9999 : (x < -16'sd9999 ? -16'sd9999 : x);
    y = y > 16'sd9999 ? 16'sd9999 : (y < -16'sd9999 ? -16'sd9999 : y);
    rng = x < y ? {y, x} : {x, y};
  endfunction
  task automatic finish_test;
  begin
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  initial
  begin
    repeat (40000) @(posedge clk_i);
    mismatches++;
    finish_test;
  end
  initial
  begin
    v = $urandom(12);
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    rd_reg(`MLC_ADDR_STATUS, v);
    chk(v[4:3], `MLC_TL_DISABLED); // no channel
    rd_reg(10'h3fc, v);
    chk(v, 32'h0);
    rd_reg(`MLC_ADDR_LABEL + 10'h020, v);
    chk(v, 32'h20); // last char
    wr_reg(`MLC_ADDR_CHCFG + 10'h004, 32'h8073);
    rd_reg(`MLC_ADDR_CHCFG + 10'h004, v);
    chk(v, 32'h9d50); // clamps
    for (i = 0; i < 5; i++)
    begin
      a = (i == 0) ? 16'sh2ee0 : 16'($urandom_range(19998)) - 16'sd9999;
      b = (i == 0) ? -16'sh2ee0 : 16'($urandom_range(19998)) - 16'sd9999;
      wr_reg(`MLC_ADDR_RANGE, {b, a});
      rd_reg(`MLC_ADDR_RANGE, v);
      chk(v, rng(a, b)); // sorted
    end
    wr_reg(`MLC_ADDR_CHCFG, 32'h305);
    wr_reg(`MLC_ADDR_CHCFG + 10'h008, 32'h6);
    repeat (30) @(posedge clk_i);
    rd_reg(`MLC_ADDR_TIME_LEFT, v);
    chk(v, 32'h800); // estimate
    mv <= 16'($urandom_range(4000));
    mval <= 1'b1;
    @(posedge clk_i);
    mch <= 3'h2;
    @(posedge clk_i);
    mval <= 1'b0;
    @(posedge clk_i);
    for (i = 0; i < 15; i++)
    begin
      wr_reg(`MLC_ADDR_CTRL, 32'(i) << 3);
      tk(PER_SEC[i] % 12'he10, 2); // aligned
      chk({16'h0, mem_u.last_val[0]}, {16'h0, mv + 16'h0003}); // offset
      chk({16'h0, mem_u.last_val[2]}, {18'h0, mv[15:2]}); // averaged
      if (i > 0)
        tk(PER_SEC[i] - 12'h001, 0); // off interval
    end
    for (j = 0; j < 6; j++)
    begin
      wr_reg(`MLC_ADDR_CTRL, 32'(j / 2) << 1);
      gate <= j[0];
      tk(12'h000, (j < 2 || (j / 2 == 1) == j[0]) ? 2 : 0); // gating
    end
    wr_reg(`MLC_ADDR_CTRL, 32'h0);
    wr_reg(`MLC_ADDR_IRQ_MASK, 32'h2);
    rd_reg(`MLC_ADDR_USED, v);
    chk(v, 32'(mem_u.writes)); // used words
    for (j = 0; j < 8; j++)
      wr_reg(10'(`MLC_ADDR_CHCFG + 4 * j), 32'h5);
    wr_reg(`MLC_ADDR_CMD, 32'h2);
    rd_reg(`MLC_ADDR_USED, v);
    chk(v, 32'h0); // freed
    repeat (512) tk(12'h000, 8); // fill
    rd_reg(`MLC_ADDR_STATUS, v);
    chk(v[4:0], 32'h15); // stopped
    chk(irq, 1'b1); // warning
    tk(12'h000, 0); // halted
    wr_reg(`MLC_ADDR_CMD, 32'h1);
    rd_reg(`MLC_ADDR_STATUS, v);
    chk(v[2], 1'b0); // confirmed
    wr_reg(`MLC_ADDR_IRQ_STAT, 32'h2);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0); // cleared
    wr_reg(`MLC_ADDR_CMD, 32'h2);
    tk(12'h000, 8); // resumed
    wr_reg(`MLC_ADDR_CTRL, 32'h1);
    wr_reg(`MLC_ADDR_CMD, 32'h2);
    repeat (513) tk(12'h000, 8); // keeps writing
    rd_reg(`MLC_ADDR_STATUS, v);
    chk(v[4:1], 32'hf); // overwriting
    chk(mem_u.wrapped, 1'b1); // from start
    wr_reg(`MLC_ADDR_CMD, 32'h2);
    wr_reg(`MLC_ADDR_CTRL, 32'h80);
    kp(v[0]);
    repeat (58) tk(12'h000, 8);
    chk(bl, 1'b1); // still lit
    repeat (4) tk(12'h000, 8);
    chk(bl, 1'b0); // timed out
    kp(v[0]);
    chk(v[0], 1'b0); // wake only
    chk(bl, 1'b1); // relit
    kp(v[0]);
    chk(v[0], 1'b1); // key acts
    nvf <= 1'b1;
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    rd_reg(`MLC_ADDR_STATUS, v);
    chk(v[2], 1'b1); // power-up
    finish_test;
  end
endmodule // mlc_logger_test
